//--- rtl/boot_resp_params.svh
// Constants of the serial boot command responder.
`ifndef BOOT_RESP_PARAMS_SVH
`define BOOT_RESP_PARAMS_SVH

`define CMD_RAM_XFER      8'h10
`define CMD_FLASH_SUM     8'h20
`define CMD_PROD_INFO     8'h30
`define CMD_CHIP_ERASE    8'h40
`define CMD_PROTECT_SET   8'h60

`define ACK_LO_RX_ERR     4'h8
`define ACK_LO_PROTECT    4'h6
`define ACK_LO_CMD_ERR    4'h1
`define ACK_LO_OK         4'h0

`define NIB_RESET         4'h0
`define SUM_LAST_IDX      6'h02
`define INFO_CSUM_IDX     6'h3D
`define INFO_IDX_W        6

`define INFO_ID_END       6'h03
`define INFO_PART_END     6'h0F
`define INFO_PWA_IDX      6'h10
`define INFO_STAT_LO_IDX  6'h28
`define INFO_STAT_HI_IDX  6'h29

`endif

//--- rtl/boot_resp_pkg.sv
// Types shared by the serial boot command responder.
package boot_resp_pkg;

    typedef enum logic [2:0] {
        S_IDLE     = 3'b000,
        S_ACK      = 3'b001,
        S_SUM      = 3'b011,
        S_INFO     = 3'b010,
        S_WAIT_PAY = 3'b110,
        S_PAYLOAD  = 3'b111,
        S_JUMP     = 3'b101
    } state_t;

    typedef enum logic [1:0] {
        GO_NONE  = 2'h0,
        GO_RAM   = 2'h1,
        GO_ERASE = 2'h2,
        GO_PROT  = 2'h3
    } go_t;

endpackage

//--- rtl/info_record_rom.sv
// Fixed and live bytes of the product information record, bytes 5 to 65.
`timescale 1ns/1ps
`include "boot_resp_params.svh"
module info_record_rom
    import boot_resp_pkg::*;
#(
    // Part designation, twelve ASCII characters, first at the top; value is arbitrary.
    parameter logic [95:0] PART_NAME = 96'h424F_4F54_4445_5630_3120_2020
) (
    input  wire logic [5:0]  idx,
    input  wire logic [31:0] user_id,
    input  wire logic        read_protected,
    input  wire logic        write_protected,
    input  wire logic        sectored,
    output logic      [7:0]  info_byte
);

    logic [3:0] part_pos;

    always_comb begin
        part_pos  = 4'(idx - 6'h04);
        info_byte = 8'h00;
        if (idx <= `INFO_ID_END) begin
            info_byte = user_id[8*idx[1:0] +: 8];
        end else if (idx <= `INFO_PART_END) begin
            info_byte = PART_NAME[8*(4'hB - part_pos) +: 8];
        end else begin
            unique case (idx)
                6'h10: info_byte = 8'hF4;
                6'h11: info_byte = 8'hFE;
                6'h12: info_byte = 8'h02;
                6'h15: info_byte = 8'h10;
                6'h18: info_byte = 8'hFF;
                6'h19: info_byte = 8'h1D;
                6'h1C: info_byte = 8'hFF;
                6'h1D: info_byte = 8'h1F;
                6'h28: info_byte = {5'h00, ~sectored, ~write_protected,
                                    ~read_protected};
                6'h2C: info_byte = 8'h01;
                6'h2E: info_byte = 8'hFF;
                6'h2F: info_byte = 8'hFF;
                6'h30: info_byte = 8'h02;
                6'h32: info_byte = 8'h20;
                6'h36: info_byte = 8'h01;
                6'h39: info_byte = 8'h08;
                6'h3C: info_byte = 8'h20;
                default: info_byte = 8'h00;
            endcase
        end
    end

endmodule // info_record_rom

//--- rtl/boot_serial_command_responder.sv
// Byte-level command responder of the serial boot loader.
// Contract
// - Receive error in RAM payload or checksum answers 18H, then await a command.
// - Payload plus checksum summed modulo 256; nonzero answers 11H, then await command.
// - Good payload answers 10H, then jumps to the supplied 32-bit RAM start.
// - Command receive error answers previous upper nibble with low nibble 8H.
// - Unknown error-free command answers previous upper nibble with low nibble 1H.
// - Controller sends 20H for flash checksum; device echoes 20H and proceeds.
// - After the echo, the 16-bit flash sum goes out high byte first.
// - Then a check byte: two's complement of the two sum bytes' total.
// - Controller sends 30H for product information; device echoes 30H and proceeds.
// - Record bytes 5 to 8 are the user software identifier, ascending address.
// - Bytes 9 to 20 are the twelve-character part designation, space padded.
// - Bytes 21 to 24 are F4H, FEH, 02H, 00H.
// - Bytes 25 to 36 are RAM start, user RAM end, RAM end, little endian.
// - Bytes 37 to 44 are filler bytes.
// - Bytes 45, 46 are status; bits 0, 1, 2 low when protected or sectored.
// - Bytes 47 to 54 are flash start and end addresses, little endian.
// - Bytes 55, 56 are sector count 20H then 00H.
// - Bytes 57 to 65 describe thirty-two 4-Kbyte sectors.
// - Byte 66 is two's complement of the sum of bytes 5 to 65.
// - Controller sends 40H for chip erase; device echoes 40H when received cleanly.
`timescale 1ns/1ps
`include "boot_resp_params.svh"
module boot_serial_command_responder
    import boot_resp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_error,
    output logic             rx_ready,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    input  wire logic        tx_ready,
    input  wire logic [15:0] flash_sum,
    input  wire logic [31:0] user_id,
    input  wire logic        read_protected,
    input  wire logic        write_protected,
    input  wire logic        sectored,
    input  wire logic        payload_start,
    input  wire logic [15:0] payload_len,
    input  wire logic [31:0] ram_start,
    output logic             ram_xfer_go,
    output logic             erase_go,
    output logic             protect_go,
    output logic             ram_wr_en,
    output logic      [31:0] ram_wr_addr,
    output logic      [7:0]  ram_wr_data,
    output logic             jump_go,
    output logic      [31:0] jump_addr
);

    state_t      state_r,     state_nxt;
    state_t      after_r,     after_nxt;
    go_t         go_r,        go_nxt;
    logic [3:0]  nib_r,       nib_nxt;
    logic [5:0]  idx_r,       idx_nxt;
    logic [7:0]  acc_r,       acc_nxt;
    logic [15:0] cap_r,       cap_nxt;
    logic [15:0] cnt_r,       cnt_nxt;
    logic [15:0] len_r,       len_nxt;
    logic [31:0] addr_r,      addr_nxt;
    logic        err_r,       err_nxt;
    logic        rx_ready_r,  rx_ready_nxt;
    logic        tx_valid_r,  tx_valid_nxt;
    logic [7:0]  tx_data_r,   tx_data_nxt;
    logic        ram_go_r,    ram_go_nxt;
    logic        erase_go_r,  erase_go_nxt;
    logic        prot_go_r,   prot_go_nxt;
    logic        wr_en_r,     wr_en_nxt;
    logic [31:0] wr_addr_r,   wr_addr_nxt;
    logic [7:0]  wr_data_r,   wr_data_nxt;
    logic        jump_r,      jump_nxt;
    logic [31:0] jump_addr_r, jump_addr_nxt;
    logic [7:0]  info_byte;
    logic        rx_take;
    logic        tx_done;

    function automatic logic cmd_known(input logic [7:0] c);
        cmd_known = (c == `CMD_RAM_XFER) || (c == `CMD_FLASH_SUM) ||
                    (c == `CMD_PROD_INFO) || (c == `CMD_CHIP_ERASE) ||
                    (c == `CMD_PROTECT_SET);
    endfunction

    function automatic logic [7:0] twos(input logic [7:0] v);
        twos = 8'(~v + 8'h01);
    endfunction

    info_record_rom info_record_rom_inst (
        .idx             (idx_r),
        .user_id         (user_id),
        .read_protected  (read_protected),
        .write_protected (write_protected),
        .sectored        (sectored),
        .info_byte       (info_byte)
    );

    // Bytes arriving while a reply is in flight are dropped, since nothing is buffered.
    assign rx_take = rx_valid & rx_ready_r;
    assign tx_done = tx_valid_r & tx_ready;

    always_comb begin
        state_nxt     = state_r;
        after_nxt     = after_r;
        go_nxt        = go_r;
        nib_nxt       = nib_r;
        idx_nxt       = idx_r;
        acc_nxt       = acc_r;
        cap_nxt       = cap_r;
        cnt_nxt       = cnt_r;
        len_nxt       = len_r;
        addr_nxt      = addr_r;
        err_nxt       = err_r;
        tx_valid_nxt  = tx_valid_r;
        tx_data_nxt   = tx_data_r;
        ram_go_nxt    = 1'b0;
        erase_go_nxt  = 1'b0;
        prot_go_nxt   = 1'b0;
        wr_en_nxt     = 1'b0;
        wr_addr_nxt   = wr_addr_r;
        wr_data_nxt   = wr_data_r;
        jump_nxt      = 1'b0;
        jump_addr_nxt = jump_addr_r;
        unique case (state_r)
            S_IDLE: begin
                if (rx_take) begin
                    state_nxt    = S_ACK;
                    after_nxt    = S_IDLE;
                    go_nxt       = GO_NONE;
                    idx_nxt      = 6'h00;
                    acc_nxt      = 8'h00;
                    tx_valid_nxt = 1'b1;
                    if (rx_error) begin
                        tx_data_nxt = {nib_r, `ACK_LO_RX_ERR};
                    end else begin
                        nib_nxt = rx_data[7:4];
                        if (!cmd_known(rx_data)) begin
                            tx_data_nxt = {nib_r, `ACK_LO_CMD_ERR};
                        end else begin
                            tx_data_nxt = rx_data;
                            unique case (rx_data)
                                `CMD_RAM_XFER: begin
                                    if (read_protected || write_protected) begin
                                        tx_data_nxt = {nib_r, `ACK_LO_PROTECT};
                                    end else begin
                                        after_nxt = S_WAIT_PAY;
                                        go_nxt    = GO_RAM;
                                    end
                                end
                                `CMD_FLASH_SUM: begin
                                    after_nxt = S_SUM;
                                    cap_nxt   = flash_sum;
                                end
                                `CMD_PROD_INFO: after_nxt = S_INFO;
                                `CMD_CHIP_ERASE: go_nxt = GO_ERASE;
                                `CMD_PROTECT_SET: go_nxt = GO_PROT;
                            endcase
                        end
                    end
                end
            end
            S_ACK: begin
                if (tx_done) begin
                    tx_valid_nxt = 1'b0;
                    state_nxt    = after_r;
                    ram_go_nxt   = (go_r == GO_RAM);
                    erase_go_nxt = (go_r == GO_ERASE);
                    prot_go_nxt  = (go_r == GO_PROT);
                end
            end
            S_SUM: begin
                if (!tx_valid_r) begin
                    tx_valid_nxt = 1'b1;
                    unique case (idx_r[1:0])
                        2'h0: tx_data_nxt = cap_r[15:8];
                        2'h1: tx_data_nxt = cap_r[7:0];
                        default: tx_data_nxt = twos(8'(cap_r[15:8] + cap_r[7:0]));
                    endcase
                end else if (tx_done) begin
                    tx_valid_nxt = 1'b0;
                    idx_nxt      = 6'(idx_r + 6'h01);
                    if (idx_r == `SUM_LAST_IDX) begin
                        state_nxt = S_IDLE;
                    end
                end
            end
            S_INFO: begin
                if (!tx_valid_r) begin
                    tx_valid_nxt = 1'b1;
                    if (idx_r == `INFO_CSUM_IDX) begin
                        tx_data_nxt = twos(acc_r);
                    end else begin
                        tx_data_nxt = info_byte;
                        acc_nxt     = 8'(acc_r + info_byte);
                    end
                end else if (tx_done) begin
                    tx_valid_nxt = 1'b0;
                    idx_nxt      = 6'(idx_r + 6'h01);
                    if (idx_r == `INFO_CSUM_IDX) begin
                        state_nxt = S_IDLE;
                    end
                end
            end
            S_WAIT_PAY: begin
                // The password and address stages run outside; they hand over here.
                if (payload_start) begin
                    state_nxt = S_PAYLOAD;
                    len_nxt   = payload_len;
                    addr_nxt  = ram_start;
                    cnt_nxt   = 16'h0000;
                    acc_nxt   = 8'h00;
                    err_nxt   = 1'b0;
                end
            end
            S_PAYLOAD: begin
                if (rx_take) begin
                    acc_nxt = 8'(acc_r + rx_data);
                    err_nxt = err_r | rx_error;
                    if (cnt_r != len_r) begin
                        cnt_nxt     = 16'(cnt_r + 16'h0001);
                        wr_en_nxt   = ~rx_error;
                        wr_addr_nxt = 32'(addr_r + {16'h0000, cnt_r});
                        wr_data_nxt = rx_data;
                    end else begin
                        state_nxt    = S_ACK;
                        go_nxt       = GO_NONE;
                        tx_valid_nxt = 1'b1;
                        after_nxt    = S_IDLE;
                        if (err_r || rx_error) begin
                            tx_data_nxt = {nib_r, `ACK_LO_RX_ERR};
                        end else if (8'(acc_r + rx_data) != 8'h00) begin
                            tx_data_nxt = {nib_r, `ACK_LO_CMD_ERR};
                        end else begin
                            tx_data_nxt = {nib_r, `ACK_LO_OK};
                            after_nxt   = S_JUMP;
                        end
                    end
                end
            end
            S_JUMP: begin
                jump_nxt      = 1'b1;
                jump_addr_nxt = addr_r;
                state_nxt     = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
        rx_ready_nxt = (state_nxt == S_IDLE) || (state_nxt == S_PAYLOAD);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r     <= S_IDLE;
            after_r     <= S_IDLE;
            go_r        <= GO_NONE;
            nib_r       <= `NIB_RESET;
            idx_r       <= 6'h00;
            acc_r       <= 8'h00;
            cap_r       <= 16'h0000;
            cnt_r       <= 16'h0000;
            len_r       <= 16'h0000;
            addr_r      <= 32'h0000_0000;
            err_r       <= 1'b0;
            rx_ready_r  <= 1'b0;
            tx_valid_r  <= 1'b0;
            tx_data_r   <= 8'h00;
            ram_go_r    <= 1'b0;
            erase_go_r  <= 1'b0;
            prot_go_r   <= 1'b0;
            wr_en_r     <= 1'b0;
            wr_addr_r   <= 32'h0000_0000;
            wr_data_r   <= 8'h00;
            jump_r      <= 1'b0;
            jump_addr_r <= 32'h0000_0000;
        end else begin
            state_r     <= state_nxt;
            after_r     <= after_nxt;
            go_r        <= go_nxt;
            nib_r       <= nib_nxt;
            idx_r       <= idx_nxt;
            acc_r       <= acc_nxt;
            cap_r       <= cap_nxt;
            cnt_r       <= cnt_nxt;
            len_r       <= len_nxt;
            addr_r      <= addr_nxt;
            err_r       <= err_nxt;
            rx_ready_r  <= rx_ready_nxt;
            tx_valid_r  <= tx_valid_nxt;
            tx_data_r   <= tx_data_nxt;
            ram_go_r    <= ram_go_nxt;
            erase_go_r  <= erase_go_nxt;
            prot_go_r   <= prot_go_nxt;
            wr_en_r     <= wr_en_nxt;
            wr_addr_r   <= wr_addr_nxt;
            wr_data_r   <= wr_data_nxt;
            jump_r      <= jump_nxt;
            jump_addr_r <= jump_addr_nxt;
        end
    end

    assign rx_ready    = rx_ready_r;
    assign tx_valid    = tx_valid_r;
    assign tx_data     = tx_data_r;
    assign ram_xfer_go = ram_go_r;
    assign erase_go    = erase_go_r;
    assign protect_go  = prot_go_r;
    assign ram_wr_en   = wr_en_r;
    assign ram_wr_addr = wr_addr_r;
    assign ram_wr_data = wr_data_r;
    assign jump_go     = jump_r;
    assign jump_addr   = jump_addr_r;

    sequence cmd_in(logic [7:0] c);
        state_r == S_IDLE && rx_take && !rx_error && rx_data == c;
    endsequence

    sequence ok_ack_sent;
        state_r == S_ACK && after_r == S_JUMP && tx_done;
    endsequence

    a_cmd_rx_err: assert property (@(posedge sys_clk) disable iff (reset)
        state_r == S_IDLE && rx_take && rx_error |=>
        tx_valid_r && tx_data_r == {$past(nib_r), 4'h8})
        else $error("command receive error not answered with x8H");

    a_cmd_unknown: assert property (@(posedge sys_clk) disable iff (reset)
        state_r == S_IDLE && rx_take && !rx_error && !cmd_known(rx_data) |=>
        tx_data_r == {$past(nib_r), 4'h1} && state_r == S_ACK)
        else $error("unknown command not answered with x1H");

    a_nib_hold: assert property (@(posedge sys_clk) disable iff (reset)
        !(state_r == S_IDLE && rx_take && !rx_error) |=> $stable(nib_r))
        else $error("command nibble changed without a clean command");

    a_sum_echo: assert property (@(posedge sys_clk) disable iff (reset)
        cmd_in(`CMD_FLASH_SUM) |=> tx_data_r == 8'h20 && after_r == S_SUM)
        else $error("flash sum command not echoed");

    a_sum_order: assert property (@(posedge sys_clk) disable iff (reset)
        state_r == S_SUM && tx_valid_r && idx_r == 6'h00 |->
        tx_data_r == cap_r[15:8])
        else $error("flash sum high byte not first");

    a_sum_check: assert property (@(posedge sys_clk) disable iff (reset)
        state_r == S_SUM && tx_valid_r && idx_r == 6'h02 |->
        8'(tx_data_r + cap_r[15:8] + cap_r[7:0]) == 8'h00)
        else $error("flash sum check byte wrong");

    a_info_echo: assert property (@(posedge sys_clk) disable iff (reset)
        cmd_in(`CMD_PROD_INFO) |=> tx_data_r == 8'h30 && state_r == S_ACK && after_r == S_INFO)
        else $error("information command not echoed");

    a_info_pwa: assert property (@(posedge sys_clk) disable iff (reset)
        state_r == S_INFO && tx_valid_r && idx_r == `INFO_PWA_IDX |-> tx_data_r == 8'hF4)
        else $error("password start address byte wrong");

    a_erase_echo: assert property (@(posedge sys_clk) disable iff (reset)
        cmd_in(`CMD_CHIP_ERASE) |=> tx_data_r == 8'h40 ##[1:1000] erase_go_r)
        else $error("erase command not echoed before go");

    a_pay_csum: assert property (@(posedge sys_clk) disable iff (reset)
        state_r == S_PAYLOAD && rx_take && cnt_r == len_r && !err_r && !rx_error &&
        8'(acc_r + rx_data) != 8'h00 |=> tx_data_r == {nib_r, 4'h1} && after_r == S_IDLE)
        else $error("bad payload checksum not answered with 11H");

    a_pay_rx_err: assert property (@(posedge sys_clk) disable iff (reset)
        state_r == S_PAYLOAD && rx_take && cnt_r == len_r && (err_r || rx_error) |=>
        tx_data_r[3:0] == 4'h8 && after_r == S_IDLE)
        else $error("payload receive error not answered with x8H");

    a_jump_after: assert property (@(posedge sys_clk) disable iff (reset)
        ok_ack_sent |-> ##2 jump_r && jump_addr_r == addr_r)
        else $error("jump not taken after good payload");

    a_tx_hold: assert property (@(posedge sys_clk) disable iff (reset)
        tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r))
        else $error("reply byte withdrawn before it was taken");

endmodule // boot_serial_command_responder

//--- sim/uart_ctrl_model.sv
// Behavioural programming controller on the far side of the boot responder.
`timescale 1ns/1ps
module uart_ctrl_model (
    input  wire logic       sys_clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            rx_error,
    input  wire logic       slow
);
    logic [7:0] got_q[$];
    logic [1:0] pace;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_error = 1'b0;
        pace = 2'h0;
    end
    // Slow mode takes one reply byte in four cycles, so held replies get exercised.
    always @(posedge sys_clk) begin
        if (tx_valid && tx_ready) begin
            got_q.push_back(tx_data);
        end
        pace <= pace + 2'h1;
        tx_ready <= !slow || (pace == 2'h3);
    end
    // One byte pulse; the idle line shows the inverse so stale data is never reused.
    task automatic send(input logic [7:0] b, input logic e);
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        rx_data <= b;
        rx_error <= e;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_data <= ~b;
        rx_error <= 1'b0;
    endtask
endmodule // uart_ctrl_model

//--- sim/test_boot_serial_command_responder.sv
// Self-checking bench of the serial boot command responder.
`timescale 1ns/1ps
module test_boot_serial_command_responder
    import boot_resp_pkg::*;
;
    logic        sys_clk, reset, rx_valid, rx_error, rx_ready, tx_valid, tx_ready, slow;
    logic [7:0]  rx_data, tx_data, ram_wr_data, last_data;
    logic        read_protected, write_protected, sectored, payload_start;
    logic        ram_xfer_go, erase_go, protect_go, ram_wr_en, jump_go;
    logic [15:0] flash_sum, payload_len;
    logic [31:0] user_id, ram_start, ram_wr_addr, jump_addr, last_addr;
    int          err_count, cmp_count, xfer_n, erase_n, wr_n, jump_n, prot_n;
    logic [7:0]  tbl [45] = '{8'hF4, 8'hFE, 8'h02, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'hFF,
        8'h1D, 8'h00, 8'h00, 8'hFF, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'hFF, 8'hFF, 8'h02,
        8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h20};

    boot_serial_command_responder boot_serial_command_responder_inst (
        .sys_clk(sys_clk), .reset(reset), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_error(rx_error), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .flash_sum(flash_sum), .user_id(user_id),
        .read_protected(read_protected), .write_protected(write_protected),
        .sectored(sectored), .payload_start(payload_start), .payload_len(payload_len),
        .ram_start(ram_start), .ram_xfer_go(ram_xfer_go), .erase_go(erase_go),
        .protect_go(protect_go), .ram_wr_en(ram_wr_en), .ram_wr_addr(ram_wr_addr),
        .ram_wr_data(ram_wr_data), .jump_go(jump_go), .jump_addr(jump_addr));
    uart_ctrl_model uart_ctrl_model_inst (.sys_clk(sys_clk), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_error(rx_error), .slow(slow));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (ram_xfer_go) xfer_n++;
        if (erase_go) erase_n++;
        if (protect_go) prot_n++;
        if (jump_go) jump_n++;
        if (ram_wr_en) begin
            wr_n++;
            last_addr = ram_wr_addr;
            last_data = ram_wr_data;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("compares %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic hang;
        err_count++;
        $display("[ERR] %0t wait ran out", $time);
        test_done();
    endtask
    task automatic put(input logic [7:0] b, input logic e);
        int i;
        // Called on an edge, so let the design's own update settle before looking.
        #1;
        for (i = 0; i < 300 && rx_ready !== 1'b1; i++) @(posedge sys_clk) #1;
        if (i == 300) hang();
        uart_ctrl_model_inst.send(b, e);
    endtask
    // Waits for n reply bytes, then lets the pulses that follow a reply land.
    task automatic get(input int n);
        int i;
        for (i = 0; i < 3000 && uart_ctrl_model_inst.got_q.size() < n; i++) @(posedge sys_clk);
        if (i == 3000) hang();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    function automatic logic [7:0] q(input int k);
        return uart_ctrl_model_inst.got_q[k];
    endfunction

    task automatic sum_scn;
        uart_ctrl_model_inst.got_q.delete();
        flash_sum <= 16'hA53C;
        slow <= 1'b1;
        put(8'h20, 1'b0);
        get(4);
        chk(q(0), 8'h20);
        chk({q(1), q(2)}, 16'hA53C);
        chk(q(3), 8'h1F);
        slow <= 1'b0;
    endtask
    task automatic err_scn;
        uart_ctrl_model_inst.got_q.delete();
        put(8'h55, 1'b0);
        put(8'h77, 1'b1);
        get(2);
        chk(q(0), 8'h21);
        chk(q(1), 8'h58);
    endtask
    task automatic info_scn;
        logic [7:0] s;
        s = 8'h00;
        uart_ctrl_model_inst.got_q.delete();
        read_protected <= 1'b1;
        user_id <= 32'h4433_2211;
        put(8'h30, 1'b0);
        get(63);
        chk(q(0), 8'h30);
        for (int k = 1; k < 5; k++) chk(q(k), 8'h11 * k);
        for (int k = 5; k < 17; k++) chk(q(k) >= 8'h20 && q(k) <= 8'h7E, 1'b1);
        for (int k = 0; k < 34; k++) begin
            chk(q(17 + k), tbl[k]);
        end
        for (int k = 34; k < 45; k++) chk(q(17 + k), tbl[k]);
        for (int k = 1; k < 62; k++) s = s + q(k);
        chk(q(62), 8'(8'h00 - s));
        read_protected <= 1'b0;
    endtask
    task automatic erase_scn;
        int n;
        n = erase_n;
        uart_ctrl_model_inst.got_q.delete();
        put(8'h40, 1'b0);
        get(1);
        chk(q(0), 8'h40);
        chk(erase_n, n + 1);
    endtask
    // Protect set is echoed; a RAM transfer under write protection answers x6H.
    task automatic prot_scn;
        int p, x;
        p = prot_n;
        x = xfer_n;
        uart_ctrl_model_inst.got_q.delete();
        put(8'h60, 1'b0);
        get(1);
        write_protected <= 1'b1;
        put(8'h10, 1'b0);
        get(2);
        chk(q(0), 8'h60);
        chk(q(1), 8'h66);
        chk(prot_n - p, 1);
        chk(xfer_n - x, 0);
        write_protected <= 1'b0;
    endtask
    // Two payload bytes AB, CD; a good checksum for them is 88.
    task automatic ram_scn(input logic [7:0] ck, input logic e, input logic [7:0] exp);
        int w, j, x;
        w = wr_n;
        j = jump_n;
        x = xfer_n;
        uart_ctrl_model_inst.got_q.delete();
        put(8'h10, 1'b0);
        get(1);
        @(posedge sys_clk);
        payload_start <= 1'b1;
        @(posedge sys_clk);
        payload_start <= 1'b0;
        put(8'hAB, e);
        put(8'hCD, 1'b0);
        put(ck, 1'b0);
        get(2);
        chk(q(1), exp);
        chk(xfer_n - x, 1);
        chk(wr_n - w, e ? 1 : 2);
        chk({last_addr, last_data}, {32'h0000_1001, 8'hCD});
        chk(jump_n - j, exp == 8'h10);
        if (exp == 8'h10) chk(jump_addr, 32'h0000_1000);
    endtask

    initial begin
        {err_count, cmp_count, xfer_n, erase_n, wr_n, jump_n, prot_n} = '0;
        {rx_valid, rx_error, slow, payload_start} = '0;
        {read_protected, write_protected, sectored} = '0;
        flash_sum = 16'h0000;
        user_id = 32'h0000_0000;
        payload_len = 16'h0002;
        ram_start = 32'h0000_1000;
        reset = 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        sum_scn();
        err_scn();
        info_scn();
        erase_scn();
        prot_scn();
        ram_scn(8'h88, 1'b0, 8'h10);
        ram_scn(8'h89, 1'b0, 8'h11);
        ram_scn(8'h88, 1'b1, 8'h18);
        test_done();
    end
endmodule // test_boot_serial_command_responder
